// ==== verilog/rhythm_pattern_sequencer.sv ====
// Rhythm pattern sequencer top: tempo halver, bit counter, pattern and feature stores
//
// Behaviour
// R1: Six-stage bit counter restarts after any bit position from one to sixty-four.
// R2: Five stored cycle lengths, chosen electrically at run time, tempo untouched.
// R3: Counter addresses rhythm store: nine patterns by seven instruments per count.
// R4: Feature store gives four outputs, pattern chosen by active cycle condition.
// R5: Tempo clock halved before stepping counter; one bit lasts two tempo periods.
// R6: Nine active-low pattern selects, any number together, contributions ORed.
// R7: Instrument active when its stored bit is set for any active pattern.
// R8: Run inactive holds halver and counter at count one, instruments off.
// R9: Run going active shows the count-one pattern without waiting for a tempo edge.
// R10: While running, counter advances with halved tempo pulses.
// R11: Undriven control inputs read inactive and have no effect.
// R12: Instrument and feature outputs are active-low open drain, on for set bits.
// R13: Outside party asserts at most one cycle select; none selects default.
// R14: Stored reset mark ends the cycle; counter returns to one after it.
// R15: Inputs synchronised; cycle selection sampled when the counter wraps.
// R16: Count beyond a newly shortened cycle runs on to sixty-four, then wraps.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module rhythm_pattern_sequencer
    import seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tempo_clk,
    input wire logic run_n,
    input wire logic [NUM_PAT-1:0] pat_sel_n,
    input wire logic [3:0] cyc_sel_n,
    input wire logic [NUM_VOICE-1:0] instr_i,
    output logic [NUM_VOICE-1:0] instr_o,
    output logic [NUM_VOICE-1:0] instr_oe,
    input wire logic [NUM_FEAT-1:0] feat_i,
    output logic [NUM_FEAT-1:0] feat_o,
    output logic [NUM_FEAT-1:0] feat_oe,
    input wire axil_req_t axil_req,
    output axil_rsp_t axil_rsp
);
    logic rst_meta_q, rst_sync_q;
    logic [SYNC_W-1:0] ctl_s;
    logic tempo_s, run_s, tempo_prev_q, tempo_rise, run_act;
    logic [3:0] cyc_s;
    logic [NUM_PAT-1:0] pat_s;
    logic halver_q;
    logic [CNT_W-1:0] count_q;
    logic [COND_W-1:0] cond_q, cond_now;
    logic row_mark, wrap, adv;
    logic [NUM_VOICE-1:0] voice_or;
    logic [NUM_VOICE-1:0] voice_mem [NUM_COUNTS][NUM_PAT];
    logic [NUM_FEAT:0] cond_mem [NUM_COUNTS][NUM_COND];
    logic wr_en, wr_err, rd_err;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic wr_voice, wr_cond, rd_voice, rd_cond;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers; idle level is inactive, as a pulled-up open input
    sync_bits #(
        .W(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk(sys_clk),
        .rst_n(rst_sync_q),
        .d({run_n, cyc_sel_n, pat_sel_n, tempo_clk}),
        .q(ctl_s)
    ); // R15 R11

    assign tempo_s = ctl_s[0];
    assign pat_s = ctl_s[NUM_PAT:1];
    assign cyc_s = ctl_s[NUM_PAT+4:NUM_PAT+1];
    assign run_s = ctl_s[SYNC_W-1];
    assign run_act = !run_s; // R11
    assign tempo_rise = tempo_s && !tempo_prev_q;

    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            tempo_prev_q <= 1'b0;
        end
        else
        begin
            tempo_prev_q <= tempo_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle condition decode; several selects at once fall back to priority A..D
    always_comb
    begin
        if (!cyc_s[0])
            cond_now = COND_A;
        else if (!cyc_s[1])
            cond_now = COND_B;
        else if (!cyc_s[2])
            cond_now = COND_C;
        else if (!cyc_s[3])
            cond_now = COND_D;
        else
            cond_now = COND_N; // R13
    end

    ////////////////////////////////////////////////////////////////////////
    // Tempo halver and bit counter
    assign row_mark = cond_mem[count_q][cond_q][COND_MARK_BIT];
    assign wrap = row_mark || (count_q == COUNT_LAST); // R14 R16 R1
    assign adv = run_act && tempo_rise && halver_q; // R5 R10

    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            halver_q <= 1'b0;
        end
        else if (!run_act)
        begin
            halver_q <= 1'b0; // R8
        end
        else if (tempo_rise)
        begin
            halver_q <= !halver_q; // R5
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            count_q <= COUNT_ONE;
        end
        else if (!run_act)
        begin
            count_q <= COUNT_ONE; // R8
        end
        else if (adv)
        begin
            count_q <= wrap ? COUNT_ONE : count_q + 6'h01; // R1 R14 R10
        end
    end

    // Selection only changes at a wrap or while stopped, so a cycle never mixes two lengths
    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            cond_q <= COND_N;
        end
        else if (!run_act || (adv && wrap))
        begin
            cond_q <= cond_now; // R15 R2
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pattern overlay
    always_comb
    begin
        voice_or = '0;
        for (int p = 0; p < NUM_PAT; p++)
        begin
            if (!pat_s[p])
                voice_or = voice_or | voice_mem[count_q][p]; // R3 R6 R7
        end
    end

    // Open-drain drivers: low level driven only while the stored bit is set
    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            instr_o <= '0;
            instr_oe <= '0;
            feat_o <= '0;
            feat_oe <= '0;
        end
        else
        begin
            instr_o <= '0; // R12
            feat_o <= '0;
            instr_oe <= run_act ? voice_or : '0; // R8 R9 R12
            feat_oe <= cond_mem[count_q][cond_q][NUM_FEAT-1:0]; // R4 R12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    axil_port u_bus (
        .clk(sys_clk),
        .rst_n(rst_sync_q),
        .req(axil_req),
        .rsp(axil_rsp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // Address decode; status and holes are refused on write
    always_comb
    begin
        wr_voice = 1'b0;
        wr_cond = 1'b0;
        if ((wr_addr >= VOICE_BASE) && (wr_addr <= VOICE_LAST))
            wr_voice = wr_addr[5:2] < 4'(NUM_PAT);
        else if ((wr_addr >= COND_BASE) && (wr_addr <= COND_LAST))
            wr_cond = wr_addr[4:2] < 3'(NUM_COND);
    end
    assign wr_err = !(wr_voice || wr_cond);

    always_comb
    begin
        rd_voice = 1'b0;
        rd_cond = 1'b0;
        if ((rd_addr >= VOICE_BASE) && (rd_addr <= VOICE_LAST))
            rd_voice = rd_addr[5:2] < 4'(NUM_PAT);
        else if ((rd_addr >= COND_BASE) && (rd_addr <= COND_LAST))
            rd_cond = rd_addr[4:2] < 3'(NUM_COND);
    end

    // Stores are software-loaded; all patterns start empty, cycle length 64
    always_ff @(posedge sys_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            for (int c = 0; c < NUM_COUNTS; c++)
            begin
                for (int p = 0; p < NUM_PAT; p++)
                    voice_mem[c][p] <= VOICE_RST;
                for (int k = 0; k < NUM_COND; k++)
                    cond_mem[c][k] <= (c == NUM_COUNTS - 1) ? COND_LAST_RST : COND_ROW_RST;
            end
        end
        else if (wr_en && wr_strb[0])
        begin
            if (wr_voice)
                voice_mem[wr_addr[11:6]][wr_addr[5:2]] <= wr_data[NUM_VOICE-1:0]; // R3
            else if (wr_cond)
                cond_mem[wr_addr[10:5]][wr_addr[4:2]] <= wr_data[NUM_FEAT:0]; // R2 R4 R14
        end
    end

    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (rd_addr == STATUS_OFS)
        begin
            rd_data[ST_COUNT_LSB +: CNT_W] = count_q;
            rd_data[ST_COND_LSB +: COND_W] = cond_q;
            rd_data[ST_RUN_BIT] = run_act;
            rd_data[ST_IPIN_LSB +: NUM_VOICE] = instr_i;
            rd_data[ST_FPIN_LSB +: NUM_FEAT] = feat_i;
        end
        else if (rd_voice)
            rd_data[NUM_VOICE-1:0] = voice_mem[rd_addr[11:6]][rd_addr[5:2]];
        else if (rd_cond)
            rd_data[NUM_FEAT:0] = cond_mem[rd_addr[10:5]][rd_addr[4:2]];
        else
            rd_err = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_sync_q);

    a_idle_count_one: assert property (!run_act |=> count_q == COUNT_ONE && !halver_q) // R8
        else $error("counter not held at count one while stopped");
    a_idle_voices_off: assert property (!run_act |=> instr_oe == '0) // R8
        else $error("instrument driven while stopped");
    a_step_on_half: assert property ($changed(count_q) && run_act && $past(run_act) // R5
                                     |-> $past(halver_q) && $past(tempo_rise))
        else $error("counter stepped without a halved tempo edge");
    a_wrap_at_mark: assert property (adv && wrap |=> count_q == COUNT_ONE) // R14
        else $error("counter missed its wrap");
    a_count_inc: assert property (adv && !wrap |=> count_q == $past(count_q) + 6'h01) // R1
        else $error("counter did not advance by one");
    a_voice_overlay: assert property (run_act |=> instr_oe == $past(voice_or)) // R7
        else $error("instrument drive differs from overlay");
    a_start_pattern: assert property ($fell(run_s) |=> instr_oe == $past(voice_or)) // R9
        else $error("count-one pattern not shown at start");
    a_cond_hold: assert property (run_act && !(adv && wrap) |=> $stable(cond_q)) // R15
        else $error("cycle condition changed mid-cycle");
    a_open_drain: assert property (instr_o == '0 && feat_o == '0) // R12
        else $error("open-drain output driven high");
    a_feature_map: assert property (1'b1 |=> feat_oe // R4
                                    == $past(cond_mem[count_q][cond_q][NUM_FEAT-1:0]))
        else $error("feature output differs from store");

    // Step and hold checks on the synchronised inputs
    a_halver_flip: assert property (run_act && tempo_rise // R5
                                    |=> halver_q != $past(halver_q))
        else $error("halver did not toggle on a tempo edge");
    a_halver_hold: assert property (run_act && !tempo_rise // R5
                                    |=> $stable(halver_q))
        else $error("halver toggled without a tempo edge");
    a_count_hold: assert property (run_act && !adv // R10
                                   |=> $stable(count_q))
        else $error("counter moved without a halved tempo edge");
    a_wrap_last: assert property (adv && count_q == COUNT_LAST // R1
                                  |=> count_q == COUNT_ONE)
        else $error("counter did not wrap after the last bit");
    a_no_early_wrap: assert property (adv && !row_mark && count_q != COUNT_LAST // R14
                                      |=> count_q != COUNT_ONE)
        else $error("counter wrapped before its mark");
    a_cond_idle: assert property (!run_act // R15
                                  |=> cond_q == $past(cond_now))
        else $error("cycle condition not tracked while stopped");
    a_cond_at_wrap: assert property (adv && wrap // R2
                                     |=> cond_q == $past(cond_now))
        else $error("cycle condition not taken at the wrap");
    a_unselected_off: assert property (&pat_s // R11
                                       |=> instr_oe == '0)
        else $error("instrument driven with no pattern selected");
    a_start_count_one: assert property ($fell(run_s) // R9
                                        |=> count_q == COUNT_ONE)
        else $error("run start did not begin at count one");

    c_wrap: cover property (adv && wrap && row_mark);
    c_overlay: cover property (run_act && ($countones(~pat_s) > 1) && instr_oe != '0);
    c_cond_change: cover property (adv && wrap && cond_now != cond_q);
    c_start: cover property ($fell(run_s));
    c_stop: cover property ($rose(run_s));
endmodule
`default_nettype wire

// ==== verilog/seq_pkg.sv ====
// Shared constants, address map and bus carriers for the rhythm pattern sequencer
package seq_pkg;
    localparam int CNT_W = 6;
    localparam int NUM_COUNTS = 64;
    localparam int NUM_PAT = 9;
    localparam int PAT_W = 4;
    localparam int NUM_VOICE = 7;
    localparam int NUM_FEAT = 4;
    localparam int NUM_COND = 5;
    localparam int COND_W = 3;
    localparam int ADDR_W = 16;
    localparam int SYNC_W = 15;
    // Cycle conditions, selected by the four cycle-select inputs or by none of them
    localparam logic [COND_W-1:0] COND_A = 3'h0;
    localparam logic [COND_W-1:0] COND_B = 3'h1;
    localparam logic [COND_W-1:0] COND_C = 3'h2;
    localparam logic [COND_W-1:0] COND_D = 3'h3;
    localparam logic [COND_W-1:0] COND_N = 3'h4;
    localparam logic [CNT_W-1:0] COUNT_ONE = 6'h00;
    localparam logic [CNT_W-1:0] COUNT_LAST = 6'h3F;
    // Register map, byte addresses
    localparam logic [ADDR_W-1:0] STATUS_OFS = 16'h0000;
    localparam logic [ADDR_W-1:0] VOICE_BASE = 16'h1000;
    localparam logic [ADDR_W-1:0] VOICE_LAST = 16'h1FFC;
    localparam logic [ADDR_W-1:0] COND_BASE = 16'h2000;
    localparam logic [ADDR_W-1:0] COND_LAST = 16'h27FC;
    // Field positions
    localparam int ST_COUNT_LSB = 0;
    localparam int ST_COND_LSB = 8;
    localparam int ST_RUN_BIT = 12;
    localparam int ST_IPIN_LSB = 16;
    localparam int ST_FPIN_LSB = 24;
    localparam int COND_MARK_BIT = 4;
    // Reset values
    localparam logic [SYNC_W-1:0] SYNC_RST = 15'h7FFE;
    localparam logic [NUM_VOICE-1:0] VOICE_RST = 7'h00;
    localparam logic [NUM_FEAT:0] COND_ROW_RST = 5'h00;
    localparam logic [NUM_FEAT:0] COND_LAST_RST = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;
endpackage

// ==== verilog/sync_bits.sv ====
// Two-flop synchroniser for a group of independent level inputs
`timescale 1ns/1ns
`default_nettype none
module sync_bits #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/axil_port.sv ====
// AXI4-Lite slave front end: one write and one read under way at a time
`timescale 1ns/1ns
`default_nettype none
module axil_port
    import seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire axil_req_t req,
    output axil_rsp_t rsp,
    output logic wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    wr_state_t wr_state_q;
    logic aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    assign wr_en = (wr_state_q == WR_COLLECT) && !aw_rdy_q && !w_rdy_q;
    assign rd_addr = req.araddr;
    assign rsp = '{awready: aw_rdy_q, wready: w_rdy_q, bresp: bresp_q, bvalid: bvalid_q,
                   arready: ar_rdy_q, rdata: rdata_q, rresp: rresp_q, rvalid: rvalid_q};

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_state_q <= WR_COLLECT;
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end
        else
        begin
            case (wr_state_q)
                WR_COLLECT:
                begin
                    if (req.awvalid && aw_rdy_q)
                    begin
                        aw_rdy_q <= 1'b0;
                        wr_addr <= req.awaddr;
                    end
                    if (req.wvalid && w_rdy_q)
                    begin
                        w_rdy_q <= 1'b0;
                        wr_data <= req.wdata;
                        wr_strb <= req.wstrb;
                    end
                    if (wr_en)
                    begin
                        bvalid_q <= 1'b1;
                        bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
                        wr_state_q <= WR_RESP;
                    end
                end
                WR_RESP:
                begin
                    if (req.bready)
                    begin
                        bvalid_q <= 1'b0;
                        aw_rdy_q <= 1'b1;
                        w_rdy_q <= 1'b1;
                        wr_state_q <= WR_COLLECT;
                    end
                end
                default:
                begin
                    wr_state_q <= WR_COLLECT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: data captured at the address handshake
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ar_rdy_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else if (req.arvalid && ar_rdy_q)
        begin
            ar_rdy_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_err ? 32'h0000_0000 : rd_data;
            rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        else if (rvalid_q && req.rready)
        begin
            rvalid_q <= 1'b0;
            ar_rdy_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== bench/far_side_model.sv ====
// Far-side model: tempo source, pull-ups on the open-drain instrument and feature lines
`timescale 1ns/1ns
`default_nettype none
module far_side_model
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tempo_go,
    input wire logic tempo_slow,
    output logic tempo_clk,
    output logic tempo_busy,
    input wire logic [6:0] instr_o,
    input wire logic [6:0] instr_oe,
    output logic [6:0] instr_line,
    input wire logic [3:0] feat_o,
    input wire logic [3:0] feat_oe,
    output logic [3:0] feat_line
);
logic [4:0] ph_q;

////////////////////////////////////////////////////////////////////////////////
// One tempo pulse per request; idle low so no stray edge between pulses
always_ff @(posedge sys_clk or negedge rst_n)
begin
    if (!rst_n)
        ph_q <= 5'h00;
    else if (ph_q != 5'h00)
        ph_q <= ph_q - 5'h01;
    else if (tempo_go)
        ph_q <= tempo_slow ? 5'h10 : 5'h08;
end
assign tempo_clk = ph_q > (tempo_slow ? 5'h08 : 5'h04);
assign tempo_busy = ph_q != 5'h00;

////////////////////////////////////////////////////////////////////////////////
// Released lines float to the pull-up level
assign instr_line = (instr_oe & instr_o) | ~instr_oe;
assign feat_line = (feat_oe & feat_o) | ~feat_oe;
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking testbench for the rhythm pattern sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import seq_pkg::*;
;
logic sys_clk, rst_n, run_n, tempo_go, tempo_slow, tempo_clk, tempo_busy;
logic [8:0] pat_sel_n;
logic [3:0] cyc_sel_n, feat_o, feat_oe, feat_line;
logic [6:0] instr_o, instr_oe, instr_line;
axil_req_t req;
axil_rsp_t rsp;
logic [31:0] rd;
logic [1:0] resp;
int n_mismatch = 0;
int compares = 0;

rhythm_pattern_sequencer dut (.sys_clk(sys_clk), .rst_n(rst_n), .tempo_clk(tempo_clk), .run_n(run_n),
    .pat_sel_n(pat_sel_n), .cyc_sel_n(cyc_sel_n), .instr_i(instr_line), .instr_o(instr_o),
    .instr_oe(instr_oe), .feat_i(feat_line), .feat_o(feat_o), .feat_oe(feat_oe),
    .axil_req(req), .axil_rsp(rsp));
far_side_model model (.sys_clk(sys_clk), .rst_n(rst_n), .tempo_go(tempo_go), .tempo_slow(tempo_slow),
    .tempo_clk(tempo_clk), .tempo_busy(tempo_busy), .instr_o(instr_o), .instr_oe(instr_oe),
    .instr_line(instr_line), .feat_o(feat_o), .feat_oe(feat_oe), .feat_line(feat_line));

////////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
        n_mismatch++;
        $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic stop_test();
    if (n_mismatch == 0 && compares > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
endtask
function automatic logic [15:0] va(input int idx, input int pat);
    return VOICE_BASE | 16'(idx << 6) | 16'(pat << 2);
endfunction
function automatic logic [15:0] ca(input int idx, input int cond);
    return COND_BASE | 16'(idx << 5) | 16'(cond << 2);
endfunction

////////////////////////////////////////////////////////////////////////////////
// Bus master: address and data offered together, each dropped when taken
task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge sys_clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(aw && w))
    begin
        @(posedge sys_clk);
        if (!aw && rsp.awready === 1'b1)
        begin
            aw = 1;
            req.awvalid <= 1'b0;
        end
        if (!w && rsp.wready === 1'b1)
        begin
            w = 1;
            req.wvalid <= 1'b0;
        end
    end
    req.bready <= 1'b1;
    do @(posedge sys_clk); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    check({30'h0, resp}, {30'h0, er});
endtask
task automatic rd_chk(input logic [15:0] a, input logic [31:0] m, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
        @(posedge sys_clk);
        if (rsp.arready === 1'b1)
            req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    check(rd & m, ed);
    check({30'h0, resp}, {30'h0, er});
endtask
// Prompt and slow tempo pulses both exercised
task automatic pulse(input int n, input logic s);
    repeat (n)
    begin
        @(posedge sys_clk);
        tempo_slow <= s;
        tempo_go <= 1'b1;
        @(posedge sys_clk);
        tempo_go <= 1'b0;
        do @(posedge sys_clk); while (tempo_busy === 1'b1);
    end
    cyc(5);
endtask

////////////////////////////////////////////////////////////////////////////////
task automatic sc_stopped();
    wr(va(0, 0), 32'h05, RESP_OKAY);
    pat_sel_n <= 9'h1FE;
    cyc(6);
    check({25'h0, instr_oe}, 32'h00);
    rd_chk(STATUS_OFS, 32'hFFFFFFFF, 32'h0F7F0400, RESP_OKAY);
endtask
task automatic sc_overlay();
    wr(va(0, 3), 32'h50, RESP_OKAY);
    wr(va(0, 8), 32'h22, RESP_OKAY);
    wr(va(1, 0), 32'h01, RESP_OKAY);
    pat_sel_n <= 9'h1F6;
    cyc(6);
    check({25'h0, instr_oe}, 32'h00);
    run_n <= 1'b0;
    cyc(5);
    check({25'h0, instr_oe}, 32'h55);
    check({25'h0, instr_o}, 32'h00);
    rd_chk(STATUS_OFS, 32'h007F103F, 32'h002A1000, RESP_OKAY);
endtask
task automatic sc_halver();
    pulse(1, 1'b0);
    check({25'h0, instr_oe}, 32'h55);
    pulse(1, 1'b1);
    check({25'h0, instr_oe}, 32'h01);
    rd_chk(STATUS_OFS, 32'h0000103F, 32'h00001001, RESP_OKAY);
    pat_sel_n <= 9'h1FF;
    cyc(5);
    check({25'h0, instr_oe}, 32'h00);
    pat_sel_n <= 9'h1FE;
endtask
task automatic sc_cycle();
    run_n <= 1'b1;
    cyc(5);
    check({25'h0, instr_oe}, 32'h00);
    rd_chk(STATUS_OFS, 32'h0000003F, 32'h00, RESP_OKAY);
    wr(ca(0, COND_A), 32'h09, RESP_OKAY);
    wr(ca(2, COND_A), 32'h10, RESP_OKAY);
    wr(ca(0, COND_B), 32'h06, RESP_OKAY);
    cyc_sel_n <= 4'hE;
    cyc(6);
    check({28'h0, feat_oe}, 32'h09);
    check({28'h0, feat_o}, 32'h00);
    rd_chk(STATUS_OFS, 32'h0F00073F, 32'h06000000, RESP_OKAY);
    run_n <= 1'b0;
    pulse(2, 1'b0);
    // Selection change mid-cycle must wait for the wrap
    cyc_sel_n <= 4'hD;
    cyc(5);
    rd_chk(STATUS_OFS, 32'h0000073F, 32'h01, RESP_OKAY);
    pulse(2, 1'b1);
    check({28'h0, feat_oe}, 32'h00);
    pulse(2, 1'b0);
    rd_chk(STATUS_OFS, 32'h0F00073F, 32'h09000100, RESP_OKAY);
    check({28'h0, feat_oe}, 32'h06);
    pulse(6, 1'b0);
    rd_chk(STATUS_OFS, 32'h0000073F, 32'h0103, RESP_OKAY);
    run_n <= 1'b1;
    cyc_sel_n <= 4'hB;
    cyc(5);
    rd_chk(STATUS_OFS, 32'h00000700, 32'h00000200, RESP_OKAY);
    cyc_sel_n <= 4'h7;
    cyc(5);
    rd_chk(STATUS_OFS, 32'h00000700, 32'h00000300, RESP_OKAY);
endtask
task automatic sc_bus_err();
    rd_chk(16'h3000, 32'hFFFFFFFF, 32'h00, RESP_SLVERR);
    wr(STATUS_OFS, 32'h01, RESP_SLVERR);
    wr(va(0, 9), 32'h7F, RESP_SLVERR);
    wr(ca(1, 5), 32'h1F, RESP_SLVERR);
    rd_chk(va(0, 0), 32'hFFFFFFFF, 32'h05, RESP_OKAY);
    rd_chk(ca(0, COND_B), 32'hFFFFFFFF, 32'h06, RESP_OKAY);
endtask

////////////////////////////////////////////////////////////////////////////////
initial
begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
end
// Whole run needs a few hundred cycles
initial
begin
    #(40 * 20000);
    n_mismatch++;
    stop_test();
end
initial
begin
    rst_n = 1'b0;
    run_n = 1'b1;
    pat_sel_n = 9'h1FF;
    cyc_sel_n = 4'hF;
    tempo_go = 1'b0;
    tempo_slow = 1'b0;
    req = '0;
    req.wstrb = 4'hF;
    cyc(10);
    rst_n <= 1'b1;
    cyc(5);
    sc_stopped();
    sc_overlay();
    sc_halver();
    sc_cycle();
    sc_bus_err();
    stop_test();
end
endmodule
`default_nettype wire
